// [design/afc_consts.svh]
`ifndef AFC_CONSTS_SVH
`define AFC_CONSTS_SVH
// Purpose: constants for the output test and frame configuration block
// Assumes: 8-bit registers behind a serial control port, 7-bit address
// Notes:   all registers reset and fuse-load to zero

// Register offsets
`define AFC_ADDR_FUSE   7'h13
`define AFC_ADDR_UPLO   7'h14
`define AFC_ADDR_UPMID  7'h15
`define AFC_ADDR_PSEL   7'h16
`define AFC_ADDR_SCLK   7'h18
`define AFC_ADDR_FRAME  7'h19
// Writable bit masks and reset value
`define AFC_MASK_FUSE   8'h01
`define AFC_MASK_SCLK   8'h10
`define AFC_MASK_FRAME  8'h93
`define AFC_RST_REG     8'h00
// Field positions
`define AFC_BIT_FUSE    0
`define AFC_BIT_SCLK_ON 4
`define AFC_BIT_FSRC    7
`define AFC_BIT_FDIV    4
`define AFC_BIT_FEN     1
`define AFC_BIT_FSTR    0
// Serial frame: read flag, 7 address bits, 8 data bits
`define AFC_SPI_HDR_END 4'h7
`define AFC_SPI_END     4'hF
`endif

// [design/afc_pkg.sv]
// Purpose: shared types of the output test and frame configuration block
// Assumes: nothing
// Notes:   pattern codes are the register field values
package afc_pkg;
   typedef enum logic [2:0] {
      AFC_PAT_NORMAL = 3'h0,
      AFC_PAT_RAMP   = 3'h2,
      AFC_PAT_CONST  = 3'h3
   } afc_pat_mode_t;
   typedef enum logic [1:0] {
      AFC_SPI_IDLE = 2'h0,
      AFC_SPI_ADDR = 2'h1,
      AFC_SPI_DATA = 2'h3
   } afc_spi_st_t;
endpackage : afc_pkg

// [design/afc_pat_gen.sv]
// Purpose: per-channel test pattern insertion ahead of the bit mapper
// Assumes: one sample strobe per converter word
// Notes:   unused select codes pass normal data
module afc_pat_gen #(
   parameter int W  = 14,
   parameter int PW = 18
) (
   input  wire logic          clk_in,
   input  wire logic          rstn_in,
   input  wire logic          smp_valid_in,
   input  wire logic [2:0]    mode_in,
   input  wire logic [PW-1:0] pattern_in,
   input  wire logic [W-1:0]  data_in,
   output logic [W-1:0]       data_out
);
   logic [W-1:0] acc_ff;
   logic [W-1:0] nxt_acc;
   logic [W-1:0] out_ff;
   logic [W-1:0] nxt_out;
   logic [W-1:0] step_w;

   // Top of the user word at native width
   assign step_w   = pattern_in[PW-1 -: W];
   assign data_out = out_ff;

   // Output select per sample; mode choice ignores output format
   always_comb begin
      nxt_acc = acc_ff;
      nxt_out = out_ff;
      if (smp_valid_in) begin
         case (mode_in)
            afc_pkg::AFC_PAT_RAMP: begin
               nxt_out = acc_ff;
               nxt_acc = acc_ff + step_w;               // wraps at W bits
            end
            afc_pkg::AFC_PAT_CONST: begin
               nxt_out = step_w;
               nxt_acc = '0;
            end
            default: begin
               nxt_out = data_in;
               nxt_acc = '0;                            // Ramp restarts from zero
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         acc_ff <= '0;
         out_ff <= '0;
      end else begin
         acc_ff <= nxt_acc;
         out_ff <= nxt_out;
      end
   end

   sequence s_ramp;
      smp_valid_in && (mode_in == afc_pkg::AFC_PAT_RAMP);
   endsequence

   const_word_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      smp_valid_in && (mode_in == afc_pkg::AFC_PAT_CONST) |=> data_out == $past(step_w))
      else $error("constant pattern word wrong");
   normal_pass_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      smp_valid_in && (mode_in == afc_pkg::AFC_PAT_NORMAL) |=> data_out == $past(data_in))
      else $error("normal data not passed");
   ramp_step_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      (s_ramp ##1 s_ramp) |=> data_out == W'($past(data_out) + $past(step_w, 2)))
      else $error("ramp step wrong");
endmodule : afc_pat_gen

// [design/afc_top.sv]
// Purpose: output test pattern, serial clock buffer and frame clock configuration
// Assumes: serial control port pins and serial clock pin asynchronous to clk_in
// Notes:   fuse load fires on the 1 to 0 write of its bit
`include "afc_consts.svh"
module afc_top #(
   parameter int W  = 14,
   parameter int PW = 18
) (
   input  wire logic         clk_in,
   input  wire logic         resetn_in,
   input  wire logic         spi_sclk_in,
   input  wire logic         spi_sen_n_in,
   input  wire logic         spi_sdio_in,
   output logic              spi_sdout_out,
   input  wire logic         sample_valid_in,
   input  wire logic [W-1:0] chan_a_data_in,
   input  wire logic [W-1:0] chan_b_data_in,
   input  wire logic         dnc_frame_in,
   input  wire logic         serial_clock_input_in,
   input  wire logic         buffer_second_en_in,
   output logic [W-1:0]      chan_a_out,
   output logic [W-1:0]      chan_b_out,
   output logic              sample_valid_out,
   output logic              frame_clock_out,
   output logic              data_pin_out,
   output logic              serial_clock_in_buffer_on_out,
   output logic              fuse_map_load_out
);
   logic                rst_meta_ff;
   logic                rstn_ff;
   logic [3:0]          s1_ff, s2_ff, s3_ff, st_ff;
   logic [3:0]          nxt_st, rise_w, fall_w;
   afc_pkg::afc_spi_st_t state_ff, nxt_state;
   logic [3:0]          cnt_ff, nxt_cnt;
   logic [7:0]          sh_ff, nxt_sh;
   logic [6:0]          addr_ff, nxt_addr;
   logic                rd_ff, nxt_rd;
   logic [7:0]          rdsh_ff, nxt_rdsh;
   logic                sdout_ff, nxt_sdout;
   logic                wr_en;
   logic [7:0]          wr_data;
   logic [6:0]          hdr_addr;
   logic [7:0]          rd_data;
   logic [7:0]          fuse_ff, uplo_ff, upmid_ff, psel_ff, sclk_ff, frm_ctl_ff;
   logic [7:0]          nxt_fuse, nxt_uplo, nxt_upmid, nxt_psel, nxt_sclk, nxt_frm_ctl;
   logic                fml_ff, nxt_fml;
   logic [PW-1:0]       pattern_w;
   logic                vld_ff;
   logic [5:0]          fr_cnt_ff, nxt_fr_cnt, per_w;
   logic                frame_int_ff, nxt_frame_int;
   logic                frame_sel_w;
   logic                frame_ff, pin_ff, buf_on_ff;

   // Reset release through two flops
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_meta_ff <= 1'b0;
         rstn_ff     <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rstn_ff     <= rst_meta_ff;
      end
   end

   // Pin sync: bit 0 sclk, 1 enable, 2 data, 3 serial clock
   assign nxt_st = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & st_ff);
   assign rise_w = s2_ff & s3_ff & ~st_ff;
   assign fall_w = ~s2_ff & ~s3_ff & st_ff;
   always_ff @(posedge clk_in or negedge rstn_ff) begin
      if (!rstn_ff) begin
         s1_ff <= 4'h2;  // Enable idles high
         s2_ff <= 4'h2;
         s3_ff <= 4'h2;
         st_ff <= 4'h2;
      end else begin
         s1_ff <= {serial_clock_input_in, spi_sdio_in, spi_sen_n_in, spi_sclk_in};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         st_ff <= nxt_st;
      end
   end

   // Read mux, reserved bits already held at zero
   assign hdr_addr = {sh_ff[5:0], st_ff[2]};
   always_comb begin
      if (hdr_addr == `AFC_ADDR_FUSE) begin
         rd_data = fuse_ff;
      end else if (hdr_addr == `AFC_ADDR_UPLO) begin
         rd_data = uplo_ff;
      end else if (hdr_addr == `AFC_ADDR_UPMID) begin
         rd_data = upmid_ff;
      end else if (hdr_addr == `AFC_ADDR_PSEL) begin
         rd_data = psel_ff;
      end else if (hdr_addr == `AFC_ADDR_SCLK) begin
         rd_data = sclk_ff;
      end else if (hdr_addr == `AFC_ADDR_FRAME) begin
         rd_data = frm_ctl_ff;
      end else begin
         rd_data = 8'h00;
      end
   end

   // Serial port: shift on sclk rise, read data out on sclk fall
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_sh    = sh_ff;
      nxt_addr  = addr_ff;
      nxt_rd    = rd_ff;
      nxt_rdsh  = rdsh_ff;
      nxt_sdout = sdout_ff;
      wr_en     = 1'b0;
      wr_data   = {sh_ff[6:0], st_ff[2]};
      if (st_ff[1]) begin
         nxt_state = afc_pkg::AFC_SPI_IDLE;
         nxt_cnt   = 4'h0;
      end else begin
         if (state_ff == afc_pkg::AFC_SPI_IDLE) begin
            nxt_state = afc_pkg::AFC_SPI_ADDR;
         end
         if (rise_w[0]) begin
            nxt_sh  = wr_data;
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == `AFC_SPI_HDR_END) begin
               nxt_addr  = hdr_addr;
               nxt_rd    = sh_ff[6];
               nxt_rdsh  = rd_data;
               nxt_state = afc_pkg::AFC_SPI_DATA;
            end else if (cnt_ff == `AFC_SPI_END) begin
               wr_en     = !rd_ff;
               nxt_state = afc_pkg::AFC_SPI_ADDR;  // Next frame may follow
            end
         end else if (fall_w[0] && (state_ff == afc_pkg::AFC_SPI_DATA) && rd_ff) begin
            nxt_sdout = rdsh_ff[7];
            nxt_rdsh  = {rdsh_ff[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_ff) begin
      if (!rstn_ff) begin
         state_ff <= afc_pkg::AFC_SPI_IDLE;
         cnt_ff   <= 4'h0;
         sh_ff    <= 8'h00;
         addr_ff  <= 7'h00;
         rd_ff    <= 1'b0;
         rdsh_ff  <= 8'h00;
         sdout_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         sh_ff    <= nxt_sh;
         addr_ff  <= nxt_addr;
         rd_ff    <= nxt_rd;
         rdsh_ff  <= nxt_rdsh;
         sdout_ff <= nxt_sdout;
      end
   end

   // Register writes; fuse load wipes every earlier write
   always_comb begin
      nxt_fuse  = fuse_ff;
      nxt_uplo  = uplo_ff;
      nxt_upmid = upmid_ff;
      nxt_psel  = psel_ff;
      nxt_sclk  = sclk_ff;
      nxt_frm_ctl = frm_ctl_ff;
      nxt_fml   = 1'b0;
      if (wr_en && (addr_ff == `AFC_ADDR_FUSE) && fuse_ff[`AFC_BIT_FUSE] && !wr_data[`AFC_BIT_FUSE]) begin
         nxt_fuse  = `AFC_RST_REG;  // sequence relies on host order
         nxt_uplo  = `AFC_RST_REG;
         nxt_upmid = `AFC_RST_REG;
         nxt_psel  = `AFC_RST_REG;
         nxt_sclk  = `AFC_RST_REG;
         nxt_frm_ctl = `AFC_RST_REG;
         nxt_fml   = 1'b1;
      end else if (wr_en) begin
         // Reserved bits masked so they always read zero
         if (addr_ff == `AFC_ADDR_FUSE) begin
            nxt_fuse = wr_data & `AFC_MASK_FUSE;
         end else if (addr_ff == `AFC_ADDR_UPLO) begin
            nxt_uplo = wr_data;
         end else if (addr_ff == `AFC_ADDR_UPMID) begin
            nxt_upmid = wr_data;
         end else if (addr_ff == `AFC_ADDR_PSEL) begin
            nxt_psel = wr_data;
         end else if (addr_ff == `AFC_ADDR_SCLK) begin
            nxt_sclk = wr_data & `AFC_MASK_SCLK;
         end else if (addr_ff == `AFC_ADDR_FRAME) begin
            nxt_frm_ctl = wr_data & `AFC_MASK_FRAME;  // host picks legal combos
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_ff) begin
      if (!rstn_ff) begin
         fuse_ff  <= `AFC_RST_REG;
         uplo_ff  <= `AFC_RST_REG;
         upmid_ff <= `AFC_RST_REG;
         psel_ff  <= `AFC_RST_REG;
         sclk_ff  <= `AFC_RST_REG;
         frm_ctl_ff <= `AFC_RST_REG;
         fml_ff   <= 1'b0;
      end else begin
         fuse_ff  <= nxt_fuse;
         uplo_ff  <= nxt_uplo;
         upmid_ff <= nxt_upmid;
         psel_ff  <= nxt_psel;
         sclk_ff  <= nxt_sclk;
         frm_ctl_ff <= nxt_frm_ctl;
         fml_ff   <= nxt_fml;
      end
   end

   // Pattern word spread over three registers
   assign pattern_w = {psel_ff[1:0], upmid_ff, uplo_ff};
   afc_pat_gen #(.W(W), .PW(PW)) u_pat_a (
      .clk_in       (clk_in),
      .rstn_in      (rstn_ff),
      .smp_valid_in (sample_valid_in),
      .mode_in      (psel_ff[4:2]),
      .pattern_in   (pattern_w),
      .data_in      (chan_a_data_in),
      .data_out     (chan_a_out)
   );
   afc_pat_gen #(.W(W), .PW(PW)) u_pat_b (
      .clk_in       (clk_in),
      .rstn_in      (rstn_ff),
      .smp_valid_in (sample_valid_in),
      .mode_in      (psel_ff[7:5]),
      .pattern_in   (pattern_w),
      .data_in      (chan_b_data_in),
      .data_out     (chan_b_out)
   );

   // Frame period in serial clock rising edges: halved for two-wire, doubled when stretched
   always_comb begin
      per_w = 6'(W);
      if (frm_ctl_ff[`AFC_BIT_FDIV]) begin
         per_w = 6'(W / 2);
      end
      if (frm_ctl_ff[`AFC_BIT_FSTR]) begin
         per_w = {per_w[4:0], 1'b0};  // covers A and B words
      end
      nxt_fr_cnt    = fr_cnt_ff;
      nxt_frame_int = frame_int_ff;
      if (!buf_on_ff) begin
         nxt_fr_cnt    = 6'h00;  // no edges while buffer is off
         nxt_frame_int = 1'b0;
      end else if (rise_w[3]) begin
         nxt_fr_cnt    = (fr_cnt_ff >= per_w - 6'h01) ? 6'h00 : fr_cnt_ff + 6'h01;
         nxt_frame_int = nxt_fr_cnt < {1'b0, per_w[5:1]};
      end
   end
   assign frame_sel_w = frm_ctl_ff[`AFC_BIT_FSRC] ? dnc_frame_in : frame_int_ff;

   // Output flops; pin carries frame or parallel data
   always_ff @(posedge clk_in or negedge rstn_ff) begin
      if (!rstn_ff) begin
         fr_cnt_ff    <= 6'h00;
         frame_int_ff <= 1'b0;
         frame_ff     <= 1'b0;
         pin_ff       <= 1'b0;
         buf_on_ff    <= 1'b0;
         vld_ff       <= 1'b0;
      end else begin
         fr_cnt_ff    <= nxt_fr_cnt;
         frame_int_ff <= nxt_frame_int;
         frame_ff     <= frame_sel_w;
         pin_ff       <= frm_ctl_ff[`AFC_BIT_FEN] ? frame_sel_w : chan_a_out[0];
         buf_on_ff    <= sclk_ff[`AFC_BIT_SCLK_ON] & buffer_second_en_in;
         vld_ff       <= sample_valid_in;
      end
   end

   assign spi_sdout_out                 = sdout_ff;
   assign sample_valid_out              = vld_ff;
   assign frame_clock_out               = frame_ff;
   assign data_pin_out                  = pin_ff;
   assign serial_clock_in_buffer_on_out = buf_on_ff;
   assign fuse_map_load_out             = fml_ff;

   fuse_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_ff)
      wr_en && (addr_ff == `AFC_ADDR_FUSE) && fuse_ff[0] && !wr_data[0]
      |=> fml_ff && (pattern_w == '0) && (psel_ff == 8'h00) && (sclk_ff == 8'h00) && (frm_ctl_ff == 8'h00))
      else $error("fuse load did not clear");
   buffer_gate_a: assert property (@(posedge clk_in) disable iff (!rstn_ff)
      !(sclk_ff[4] && buffer_second_en_in) |=> !buf_on_ff ##1 (fr_cnt_ff == 6'h00))
      else $error("buffer on without both enables");
   frame_src_a: assert property (@(posedge clk_in) disable iff (!rstn_ff)
      frm_ctl_ff[7] |=> frame_ff == $past(dnc_frame_in))
      else $error("frame source select wrong");
   pin_frame_a: assert property (@(posedge clk_in) disable iff (!rstn_ff)
      frm_ctl_ff[1] |=> pin_ff == $past(frame_sel_w))
      else $error("pin not carrying frame");
   pin_data_a: assert property (@(posedge clk_in) disable iff (!rstn_ff)
      !frm_ctl_ff[1] |=> pin_ff == $past(chan_a_out[0]))
      else $error("pin not carrying data");
   stretch_len_a: assert property (@(posedge clk_in) disable iff (!rstn_ff)
      frm_ctl_ff[0] && !frm_ctl_ff[4] |-> per_w == 6'(2 * W))
      else $error("stretched frame period wrong");
endmodule : afc_top

// [bench/afc_capture_model.sv]
// Purpose: capture side model, makes the serial clock and times the frame clock
// Assumes: frame clock sampled on the same clock as the block
// Notes:   serial clock stands still while run_in is low
module afc_capture_model (
   input  wire logic clk_in,
   input  wire logic run_in,
   input  wire logic frame_clock_in,
   output logic      serial_clock_out,
   output int        period_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev_ff;
   int   cnt_ff;

   // Serial clock of 320 ns, offset so its phase is unrelated to clk_in
   initial begin
      serial_clock_out = 1'b0;
      #7;
      forever begin
         #160;
         serial_clock_out = run_in ? ~serial_clock_out : 1'b0;
      end
   end

   // Clock cycles between frame rises; restarts on every rise
   initial begin
      prev_ff = 1'b0;
      cnt_ff = 0;
      period_out = 0;
   end
   always @(posedge clk_in) begin
      cnt_ff <= cnt_ff + 1;
      prev_ff <= frame_clock_in;
      if (frame_clock_in === 1'b1 && prev_ff === 1'b0) begin
         period_out <= cnt_ff;
         cnt_ff <= 1;
      end
   end
endmodule : afc_capture_model

// [bench/adc_output_test_frame_config_tb.sv]
// Purpose: self-checking bench for the output test and frame configuration block
// Assumes: serial port frames of 16 bits, sclk phases of 4 clk
// Notes:   frame periods judged to the nearest serial clock period
`include "afc_consts.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module adc_output_test_frame_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, resetn = 0, sclk = 0, sen_n = 1, sdio = 0, sv = 0, dnc = 0, sec_en = 0, run = 0;
   logic [13:0] da = '0, db = '0;
   wire logic   sdout, svo, frm, dpin, bon, fload, sck;
   wire logic [13:0] qa, qb;
   int          error_cnt = 0, checks_done = 0, fuse_cnt = 0, per, n0, k;
   logic [7:0]  rd;
   logic [6:0]  regs [6] = '{`AFC_ADDR_FUSE, `AFC_ADDR_UPLO, `AFC_ADDR_UPMID,
                              `AFC_ADDR_PSEL, `AFC_ADDR_SCLK, `AFC_ADDR_FRAME};
   logic [7:0]  fset [3] = '{8'h02, 8'h12, 8'h03};
   int          fper [3] = '{14, 7, 28};

   always #20 clk = ~clk;

   afc_top #(.W(14), .PW(18)) DUT (
      .clk_in(clk), .resetn_in(resetn), .spi_sclk_in(sclk), .spi_sen_n_in(sen_n),
      .spi_sdio_in(sdio), .spi_sdout_out(sdout), .sample_valid_in(sv),
      .chan_a_data_in(da), .chan_b_data_in(db), .dnc_frame_in(dnc),
      .serial_clock_input_in(sck), .buffer_second_en_in(sec_en),
      .chan_a_out(qa), .chan_b_out(qb), .sample_valid_out(svo),
      .frame_clock_out(frm), .data_pin_out(dpin),
      .serial_clock_in_buffer_on_out(bon), .fuse_map_load_out(fload)
   );

   afc_capture_model LINK (
      .clk_in(clk), .run_in(run), .frame_clock_in(frm),
      .serial_clock_out(sck), .period_out(per)
   );

   // Cycles with the fuse load pulse high
   always @(posedge clk) begin
      if (fload === 1'b1) fuse_cnt++;
   end

   // One 16-bit frame; data line goes to the inverse once released
   task automatic spi(input logic r, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [15:0] f;
      f = {r, a, d};
      q = 8'h00;
      sen_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 15; i >= 0; i--) begin
         sdio <= f[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         if (i < 8) q[i] = sdout;
         sclk <= 1'b0;
      end
      repeat (8) @(posedge clk);
      sen_n <= 1'b1;
      sdio <= ~f[0];
      repeat (4) @(posedge clk);
   endtask : spi

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      spi(1'b0, a, d, rd);
   endtask : wr

   task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
      spi(1'b1, a, 8'h00, rd);
      `CHK(rd, e)
   endtask : chk_rd

   // One converter sample, outputs judged once settled
   task automatic smp(input logic [13:0] a, input logic [13:0] b, input logic [13:0] ea, input logic [13:0] eb);
      da <= a;
      db <= b;
      sv <= 1'b1;
      @(posedge clk);
      sv <= 1'b0;
      // Valid copy is looked at mid-cycle, away from its launching edge
      @(negedge clk);
      `CHK(svo, 1'b1)
      repeat (2) @(posedge clk);
      `CHK(svo, 1'b0)
      `CHK(qa, ea)
      `CHK(qb, eb)
   endtask : smp

   task automatic print_verdict();
      $display("errors=%0d checks=%0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict

   // Hang guard, about six times the expected run
   initial begin
      #2ms;
      error_cnt++;
      print_verdict();
   end

   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      repeat (8) @(posedge clk);
      // Fuse load leads the configuration sequence
      wr(`AFC_ADDR_FUSE, 8'h01);
      wr(`AFC_ADDR_FUSE, 8'h00);
      `CHK(fuse_cnt, 1)
      foreach (regs[i]) chk_rd(regs[i], `AFC_RST_REG);
      wr(7'h17, 8'hFF);
      chk_rd(7'h17, 8'h00);
      // Reserved bits must read back as zero
      wr(`AFC_ADDR_FRAME, 8'hFF);
      chk_rd(`AFC_ADDR_FRAME, `AFC_MASK_FRAME);
      wr(`AFC_ADDR_SCLK, 8'hFF);
      chk_rd(`AFC_ADDR_SCLK, `AFC_MASK_SCLK);
      wr(`AFC_ADDR_FRAME, 8'h00);
      // Ramp A with a step that wraps, constant B
      wr(`AFC_ADDR_UPLO, 8'h00);
      wr(`AFC_ADDR_UPMID, 8'h00);
      wr(`AFC_ADDR_PSEL, 8'h6B);
      for (k = 0; k < 5; k++) smp(14'h1234, 14'h2BCD, 14'(k * 14'h3000), 14'h3000);
      // Swapped modes with the serial frame output selected
      wr(`AFC_ADDR_PSEL, 8'h4F);
      wr(`AFC_ADDR_FRAME, 8'h02);
      for (k = 0; k < 4; k++) smp(14'h0ABC, 14'h1111, 14'h3000, 14'(k * 14'h3000));
      `CHK(dpin, frm)
      wr(`AFC_ADDR_FRAME, 8'h00);
      `CHK(dpin, 1'b0) // constant word has bit 0 low
      // Recommended step value, B back to normal
      wr(`AFC_ADDR_UPLO, 8'h21);
      wr(`AFC_ADDR_PSEL, 8'h08);
      for (k = 0; k < 4; k++) smp(14'h0F0F, 14'h2468, 14'(2 * k), 14'h2468);
      // Back-to-back samples: three in a row keep stepping the ramp
      sv <= 1'b1;
      repeat (3) @(posedge clk);
      sv <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(qa, 14'h000C)
      `CHK(qb, 14'h2468)
      wr(`AFC_ADDR_PSEL, 8'h3C);
      smp(14'h1357, 14'h0246, 14'h1357, 14'h0246);
      // Pin follows data bit 0, which is now high
      `CHK(dpin, 1'b1)
      // Buffer power needs both enables
      for (k = 0; k < 4; k++) begin
         wr(`AFC_ADDR_SCLK, k[0] ? 8'h10 : 8'h00);
         sec_en <= k[1];
         repeat (4) @(posedge clk);
         `CHK(bon, k[0] & k[1])
      end
      // Internal frame: plain, two-wire adjust, stretched
      run <= 1'b1;
      for (k = 0; k < 3; k++) begin
         wr(`AFC_ADDR_FRAME, fset[k]);
         repeat (700) @(posedge clk);
         `CHK((per + 4) / 8, fper[k])
         `CHK(dpin, frm)
      end
      run <= 1'b0;
      // Downconverter frame source
      wr(`AFC_ADDR_FRAME, 8'h82);
      dnc <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK(frm, 1'b1)
      `CHK(dpin, 1'b1)
      dnc <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK(frm, 1'b0)
      // Fuse load fires on the 0 write and clears everything
      wr(`AFC_ADDR_UPMID, 8'h5A);
      n0 = fuse_cnt;
      wr(`AFC_ADDR_FUSE, 8'h01);
      `CHK(fuse_cnt - n0, 0)
      wr(`AFC_ADDR_FUSE, 8'h00);
      `CHK(fuse_cnt - n0, 1)
      foreach (regs[i]) chk_rd(regs[i], 8'h00);
      print_verdict();
   end
endmodule : adc_output_test_frame_config_tb
